// ---- hw/fsp_pkg.sv ----
// package: constants, types and register layout of the flash self-programming controller
package fsp_pkg;
    // control register bit positions
    localparam int CTL_SPEN = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_PGWR = 2;
    localparam int CTL_LOCK = 3;
    localparam int CTL_REEN = 4;
    localparam int CTL_BUSY = 6;
    localparam int CTL_IRQEN = 7;
    // command codes on bits 4..0 (bits 7, 6 and 5 are don't care)
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCKSET = 5'h09;
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    // register addresses on the plain port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_PTR_LOW = 3'h1;
    localparam logic [2:0] ADDR_PTR_HIGH = 3'h2;
    localparam logic [2:0] ADDR_DATA_LOW = 3'h3;
    localparam logic [2:0] ADDR_DATA_HIGH = 3'h4;
    localparam logic [2:0] ADDR_LOCKS = 3'h5;
    localparam logic [2:0] ADDR_STATUS = 3'h6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] LOCKS_RESET = 6'h3f;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    // store must follow the command write within this many cycles
    localparam int WINDOW_CYCLES = 4;
    // programming time
    localparam int CLK_HZ = 20_000_000;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    localparam int PROG_CYCLES = (PROG_MIN_US * (CLK_HZ / 1_000_000));
    typedef enum logic [3:0] {
        FSP_IDLE = 4'b0001,
        FSP_ARMED = 4'b0010,
        FSP_PROG = 4'b0100,
        FSP_DONE = 4'b1000
    } fsp_state_e;
    typedef enum logic [1:0] {
        OP_LOAD = 2'h0,
        OP_ERASE = 2'h1,
        OP_WRITE = 2'h2,
        OP_LOCK = 2'h3
    } fsp_op_e;
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fsp_req_s;
    // request to the flash array macro
    typedef struct packed {
        logic erase;
        logic write;
        logic [15:0] addr;
    } fsp_flash_s;
endpackage

// ---- hw/fsp_page_buffer.sv ----
// module: temporary page buffer, one write per word between clears
`timescale 1ns/1ps
module fsp_page_buffer #(
    parameter int WORD_BITS = 6
) (
    input wire logic core_clk,
    input wire logic clear,
    input wire logic wrEn,
    input wire logic [WORD_BITS-1:0] wrAddr,
    input wire logic [15:0] wrData,
    input wire logic [WORD_BITS-1:0] rdAddr,
    output logic [15:0] rdData,
    output logic wrAccepted
);
    localparam int DEPTH = 1 << WORD_BITS;
    logic [15:0] mem [DEPTH];
    logic [DEPTH-1:0] used_reg;

    // a second load to a used word is dropped
    assign wrAccepted = wrEn && !used_reg[wrAddr];

    always_ff @(posedge core_clk) begin
        if (clear) begin
            used_reg <= '0;
        end else if (wrAccepted) begin
            used_reg[wrAddr] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (wrAccepted) begin
            mem[wrAddr] <= wrData;
        end
    end

    // unloaded words read as erased
    always_ff @(posedge core_clk) begin
        rdData <= used_reg[rdAddr] ? mem[rdAddr] : 16'hffff;
    end
endmodule // fsp_page_buffer

// ---- hw/fsp_ctrl.sv ----
// module: flash self-programming sequencer with register port
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
module fsp_ctrl #(
    parameter int WORD_BITS = 6,
    parameter logic [15:0] BOOT_START = 16'h1c00,
    parameter logic [15:0] HALT_START = 16'h1c00,
    parameter int PROG_COUNT = fsp_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire fsp_pkg::fsp_req_s req,
    output logic [7:0] rdData,
    input wire logic storeExec,
    input wire logic eepromBusy,
    input wire logic bootVectorFuse,
    input wire logic [15:0] readAddr,
    output logic [15:0] resetVector,
    output logic cpuStall,
    output logic concurrentBlocked,
    output logic irq,
    output fsp_pkg::fsp_flash_s flashReq,
    output logic [15:0] flashWord,
    output logic byteSelect
);
    initial begin
        if (WORD_BITS < 1 || WORD_BITS > 8) $error("WORD_BITS out of range");
        if (PROG_COUNT < 2) $error("PROG_COUNT too small");
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ptrLow_reg;
    logic [7:0] ptrHigh_reg;
    logic [7:0] dataLow_reg;
    logic [7:0] dataHigh_reg;
    logic [5:0] locks_reg;
    logic [15:0] target_reg;
    fsp_pkg::fsp_op_e op_reg;
    fsp_pkg::fsp_state_e state_reg;
    logic [2:0] window_reg;
    logic [31:0] timer_reg;
    logic haltTarget_reg;
    logic lastAccepted_reg;
    logic bufClear;
    logic bufAccepted;
    logic [15:0] bufData;
    logic [15:0] ptr;
    logic ctrlWrite;
    logic cmdTaken;

    function automatic logic [WORD_BITS-1:0] wordField(input logic [15:0] p);
        return p[WORD_BITS:1];
    endfunction

    function automatic logic isHalting(input logic [15:0] p);
        return p >= HALT_START;
    endfunction

    assign ptr = {ptrHigh_reg, ptrLow_reg};
    assign ctrlWrite = req.wr && req.addr == fsp_pkg::ADDR_CTRL;
    // pending enable or an eeprom write blocks commands
    assign cmdTaken = ctrlWrite && !ctrl_reg[fsp_pkg::CTL_SPEN] && !eepromBusy;

    // ************************************************************
    // reset vector and fuse
    // ************************************************************
    // fuse is an input only; no path writes it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resetVector <= bootVectorFuse ? fsp_pkg::APP_RESET_ADDR : BOOT_START;
        end
    end

    // ************************************************************
    // plain registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptrLow_reg <= 8'h00;
            ptrHigh_reg <= 8'h00;
            dataLow_reg <= 8'h00;
            dataHigh_reg <= 8'h00;
        end else if (req.wr) begin
            if (req.addr == fsp_pkg::ADDR_PTR_LOW) ptrLow_reg <= req.wdata;
            if (req.addr == fsp_pkg::ADDR_PTR_HIGH) ptrHigh_reg <= req.wdata;
            if (req.addr == fsp_pkg::ADDR_DATA_LOW) dataLow_reg <= req.wdata;
            if (req.addr == fsp_pkg::ADDR_DATA_HIGH) dataHigh_reg <= req.wdata;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= fsp_pkg::FSP_IDLE;
            ctrl_reg <= fsp_pkg::CTRL_RESET;
            op_reg <= fsp_pkg::OP_LOAD;
            window_reg <= 3'h0;
            timer_reg <= 32'h0;
            target_reg <= 16'h0000;
            haltTarget_reg <= 1'b0;
            lastAccepted_reg <= 1'b0;
        end else begin
            if (ctrlWrite) begin
                ctrl_reg[fsp_pkg::CTL_IRQEN] <= req.wdata[fsp_pkg::CTL_IRQEN];
            end
            unique case (state_reg)
                fsp_pkg::FSP_IDLE: begin
                    if (cmdTaken) begin
                        // bits 0..4 per assignment
                        unique case (req.wdata[4:0])
                            fsp_pkg::CMD_LOAD: begin
                                op_reg <= fsp_pkg::OP_LOAD;
                                ctrl_reg[fsp_pkg::CTL_SPEN] <= 1'b1;
                                state_reg <= fsp_pkg::FSP_ARMED;
                            end
                            fsp_pkg::CMD_ERASE: begin
                                op_reg <= fsp_pkg::OP_ERASE;
                                ctrl_reg[fsp_pkg::CTL_SPEN] <= 1'b1;
                                ctrl_reg[fsp_pkg::CTL_ERASE] <= 1'b1;
                                state_reg <= fsp_pkg::FSP_ARMED;
                            end
                            fsp_pkg::CMD_WRITE: begin
                                op_reg <= fsp_pkg::OP_WRITE;
                                ctrl_reg[fsp_pkg::CTL_SPEN] <= 1'b1;
                                ctrl_reg[fsp_pkg::CTL_PGWR] <= 1'b1;
                                state_reg <= fsp_pkg::FSP_ARMED;
                            end
                            fsp_pkg::CMD_LOCKSET: begin
                                op_reg <= fsp_pkg::OP_LOCK;
                                ctrl_reg[fsp_pkg::CTL_SPEN] <= 1'b1;
                                ctrl_reg[fsp_pkg::CTL_LOCK] <= 1'b1;
                                state_reg <= fsp_pkg::FSP_ARMED;
                            end
                            fsp_pkg::CMD_REENABLE: begin
                                // takes effect at once; clears busy flag
                                ctrl_reg[fsp_pkg::CTL_BUSY] <= 1'b0;
                            end
                            default: begin
                            end
                        endcase
                        window_reg <= 3'(fsp_pkg::WINDOW_CYCLES);
                    end
                end
                fsp_pkg::FSP_ARMED: begin
                    if (storeExec) begin
                        // address frozen here lock ignores pointer
                        target_reg <= (op_reg == fsp_pkg::OP_LOCK) ? 16'h0000 : ptr;
                        haltTarget_reg <= isHalting(ptr) && op_reg != fsp_pkg::OP_LOCK;
                        timer_reg <= 32'(PROG_COUNT);
                        if (op_reg == fsp_pkg::OP_LOAD) begin
                            // acceptance only exists on the store edge, so keep it
                            lastAccepted_reg <= bufAccepted;
                            state_reg <= fsp_pkg::FSP_DONE;
                        end else begin
                            state_reg <= fsp_pkg::FSP_PROG;
                            if (op_reg != fsp_pkg::OP_LOCK) begin
                                ctrl_reg[fsp_pkg::CTL_BUSY] <= 1'b1;
                            end
                        end
                    end else if (window_reg == 3'h1) begin
                        // no store in time: abandon
                        ctrl_reg[5:0] <= 6'h00;
                        state_reg <= fsp_pkg::FSP_IDLE;
                    end
                    window_reg <= window_reg - 3'h1;
                end
                fsp_pkg::FSP_PROG: begin
                    timer_reg <= timer_reg - 32'h1;
                    if (timer_reg == 32'h1) begin
                        state_reg <= fsp_pkg::FSP_DONE;
                    end
                end
                fsp_pkg::FSP_DONE: begin
                    ctrl_reg[5:0] <= 6'h00;
                    haltTarget_reg <= 1'b0;
                    state_reg <= fsp_pkg::FSP_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // lock bits
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            locks_reg <= fsp_pkg::LOCKS_RESET;
        end else if (state_reg == fsp_pkg::FSP_PROG && op_reg == fsp_pkg::OP_LOCK
                     && timer_reg == 32'h1) begin
            // zero bits program, ones leave alone
            locks_reg <= locks_reg & dataLow_reg[5:0];
        end
    end

    // ************************************************************
    // buffer and flash requests
    // ************************************************************
    // clear on page write done, reenable, reset, eeprom write
    assign bufClear = rst
        || (state_reg == fsp_pkg::FSP_DONE && op_reg == fsp_pkg::OP_WRITE)
        || (cmdTaken && req.wdata[4:0] == fsp_pkg::CMD_REENABLE)
        || eepromBusy;

    fsp_page_buffer #(
        .WORD_BITS(WORD_BITS)
    ) u_buffer (
        .core_clk(core_clk),
        .clear(bufClear),
        .wrEn(state_reg == fsp_pkg::FSP_ARMED && storeExec && op_reg == fsp_pkg::OP_LOAD),
        .wrAddr(wordField(ptr)),
        .wrData({dataHigh_reg, dataLow_reg}),
        .rdAddr(wordField(target_reg)),
        .rdData(bufData),
        .wrAccepted(bufAccepted)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flashReq <= '0;
            flashWord <= 16'hffff;
            byteSelect <= 1'b0;
        end else begin
            flashReq.erase <= state_reg == fsp_pkg::FSP_PROG && op_reg == fsp_pkg::OP_ERASE;
            flashReq.write <= state_reg == fsp_pkg::FSP_PROG && op_reg == fsp_pkg::OP_WRITE;
            // page field only; word bits masked
            flashReq.addr <= {target_reg[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}};
            flashWord <= bufData;
            byteSelect <= ptr[0];
        end
    end

    // ************************************************************
    // stall, blocking, interrupt
    // ************************************************************
    // halting-section target stalls; lock never stalls
    assign cpuStall = state_reg == fsp_pkg::FSP_PROG && haltTarget_reg;
    assign concurrentBlocked = ctrl_reg[fsp_pkg::CTL_BUSY]
        && !isHalting(readAddr);
    assign irq = ctrl_reg[fsp_pkg::CTL_IRQEN] && !ctrl_reg[fsp_pkg::CTL_SPEN];

    // ************************************************************
    // read port
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                fsp_pkg::ADDR_CTRL: rdData <= ctrl_reg;
                fsp_pkg::ADDR_PTR_LOW: rdData <= ptrLow_reg;
                fsp_pkg::ADDR_PTR_HIGH: rdData <= ptrHigh_reg;
                fsp_pkg::ADDR_DATA_LOW: rdData <= dataLow_reg;
                fsp_pkg::ADDR_DATA_HIGH: rdData <= dataHigh_reg;
                fsp_pkg::ADDR_LOCKS: rdData <= {2'b11, locks_reg};
                fsp_pkg::ADDR_STATUS: rdData <= {7'h00, lastAccepted_reg};
                default: rdData <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_window;
        @(posedge core_clk) disable iff (rst)
        (state_reg == fsp_pkg::FSP_ARMED && !storeExec && window_reg == 3'h1)
            |=> !ctrl_reg[fsp_pkg::CTL_SPEN];
    endproperty
    a_window: assert property (p_window) else $error("enable not cleared");

    property p_ignore;
        @(posedge core_clk) disable iff (rst)
        (ctrlWrite && ctrl_reg[fsp_pkg::CTL_SPEN] && state_reg == fsp_pkg::FSP_PROG)
            |=> $stable(op_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("command taken while busy");

    property p_eeprom;
        @(posedge core_clk) disable iff (rst)
        (state_reg == fsp_pkg::FSP_IDLE && ctrlWrite && eepromBusy)
            |=> state_reg == fsp_pkg::FSP_IDLE;
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("command passed eeprom");

    property p_irq;
        @(posedge core_clk) disable iff (rst)
        (ctrl_reg[fsp_pkg::CTL_IRQEN] && state_reg == fsp_pkg::FSP_IDLE) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_busy;
        @(posedge core_clk) disable iff (rst)
        (state_reg == fsp_pkg::FSP_PROG && op_reg != fsp_pkg::OP_LOCK)
            |-> ctrl_reg[fsp_pkg::CTL_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag low");

    property p_lockNoStall;
        @(posedge core_clk) disable iff (rst)
        (op_reg == fsp_pkg::OP_LOCK) |-> !cpuStall;
    endproperty
    a_lockNoStall: assert property (p_lockNoStall) else $error("lock stalled cpu");

    property p_stall;
        @(posedge core_clk) disable iff (rst)
        (state_reg == fsp_pkg::FSP_ARMED && storeExec && op_reg == fsp_pkg::OP_ERASE
         && isHalting(ptr)) |=> cpuStall [*3];
    endproperty
    a_stall: assert property (p_stall) else $error("stall missing");

    property p_latch;
        @(posedge core_clk) disable iff (rst)
        (state_reg == fsp_pkg::FSP_PROG && $past(state_reg) == fsp_pkg::FSP_PROG)
            |-> $stable(target_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("target moved");

    property p_blocked;
        @(posedge core_clk) disable iff (rst)
        (flashReq.erase || flashReq.write) |-> ctrl_reg[fsp_pkg::CTL_BUSY];
    endproperty
    a_blocked: assert property (p_blocked) else $error("section not blocked");

    c_erase: cover property (@(posedge core_clk) state_reg == fsp_pkg::FSP_PROG
        && op_reg == fsp_pkg::OP_ERASE);
    c_load: cover property (@(posedge core_clk) bufAccepted);
    c_lock: cover property (@(posedge core_clk) state_reg == fsp_pkg::FSP_PROG
        && op_reg == fsp_pkg::OP_LOCK);
    c_timeout: cover property (@(posedge core_clk) state_reg == fsp_pkg::FSP_ARMED
        && window_reg == 3'h1 && !storeExec);
endmodule // fsp_ctrl

// ---- tb/fsp_cpu_model.sv ----
// partner model: cpu core that issues the store-program instruction after a command write
`timescale 1ns/1ps
module fsp_cpu_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire fsp_pkg::fsp_req_s req,
    input wire logic [2:0] storeDelay,
    output logic storeExec
);
    // ****************************************************************
    // timed store sequence
    // ****************************************************************
    logic [2:0] cnt_reg;
    // interrupts stay off from command write to store, so the gap is exact
    // delay 0 never stores: lets the bench run the window out
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            storeExec <= 1'b0;
        end else if (req.wr && req.addr == fsp_pkg::ADDR_CTRL) begin
            cnt_reg <= storeDelay;
            storeExec <= (storeDelay == 3'h1);
        end else begin
            cnt_reg <= (cnt_reg > 3'h1) ? cnt_reg - 3'h1 : 3'h0;
            storeExec <= (cnt_reg == 3'h2);
        end
    end
endmodule // fsp_cpu_model

// ---- tb/tb_flash_self_programming_ctrl.sv ----
// testbench: random and corner-case sequences for the self-programming sequencer
`timescale 1ns/1ps
module tb_flash_self_programming_ctrl;
    // ****************************************************************
    // signals and helpers
    // ****************************************************************
    localparam int PROG = 20;
    localparam logic [15:0] BOOT = 16'h1c00;
    localparam logic [2:0] CT = fsp_pkg::ADDR_CTRL;
    logic core_clk, rst, storeExec, eepromBusy, bootVectorFuse;
    logic cpuStall, concurrentBlocked, irq, byteSelect;
    fsp_pkg::fsp_req_s req;
    fsp_pkg::fsp_flash_s flashReq;
    logic [7:0] rdData, rv;
    logic [15:0] readAddr, resetVector, flashWord, ptr;
    logic [5:0] lockExp;
    logic [63:0] used;
    logic [2:0] storeDelay;
    logic [31:0] seed;
    int errors, n_compared, cycles;

    fsp_ctrl #(.PROG_COUNT(PROG)) uut (.core_clk(core_clk), .rst(rst), .req(req),
        .rdData(rdData), .storeExec(storeExec), .eepromBusy(eepromBusy),
        .bootVectorFuse(bootVectorFuse), .readAddr(readAddr), .resetVector(resetVector),
        .cpuStall(cpuStall), .concurrentBlocked(concurrentBlocked), .irq(irq),
        .flashReq(flashReq), .flashWord(flashWord), .byteSelect(byteSelect));
    fsp_cpu_model cpu (.core_clk(core_clk), .rst(rst), .req(req),
        .storeDelay(storeDelay), .storeExec(storeExec));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] vecExp(input logic fuse);
        return fuse ? fsp_pkg::APP_RESET_ADDR : BOOT;
    endfunction
    // a zero data bit programs its lock, a one leaves it alone
    function automatic logic [5:0] lockNext(input logic [5:0] old, input logic [5:0] d);
        return old & d;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 rv = rdData;
    endtask
    task automatic setPtr(input logic [15:0] p);
        wr(fsp_pkg::ADDR_PTR_LOW, p[7:0]);
        wr(fsp_pkg::ADDR_PTR_HIGH, p[15:8]);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [2:0] dly);
        storeDelay <= dly;
        wr(CT, c);
    endtask
    task automatic waitIdle;
        for (int i = 0; i < 60; i++) begin
            rd(CT);
            if (rv[0] === 1'b0) break;
        end
    endtask
    // bench keeps its own map of used buffer words to predict refusals
    task automatic load(input logic [15:0] p, input logic [15:0] d);
        logic exp;
        exp = !used[p[6:1]];
        used[p[6:1]] = 1'b1;
        wr(fsp_pkg::ADDR_DATA_LOW, d[7:0]);
        wr(fsp_pkg::ADDR_DATA_HIGH, d[15:8]);
        setPtr(p);
        cmd(8'h01, 3'h2);
        waitIdle;
        rd(fsp_pkg::ADDR_STATUS);
        chk(rv[0], exp);
        if (exp) chk(flashWord, d);
        chk(byteSelect, p[0]);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // whole run is well under a thousand cycles; this ceiling only cuts a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report;
        end
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        req = '0;
        eepromBusy = 1'b0;
        bootVectorFuse = 1'b0;
        readAddr = 16'h0000;
        storeDelay = 3'h0;
        seed = 32'hcf184868;
        used = '0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        for (int f = 0; f < 2; f++) begin
            bootVectorFuse <= f[0];
            rst <= 1'b1;
            repeat (4) @(posedge core_clk);
            rst <= 1'b0;
            @(posedge core_clk);
            #1 chk(resetVector, vecExp(f[0]));
        end
        rd(CT);
        chk(rv, fsp_pkg::CTRL_RESET);
        rd(fsp_pkg::ADDR_LOCKS);
        chk(rv[5:0], fsp_pkg::LOCKS_RESET);
        wr(3'h7, 8'hff);
        rd(3'h7);
        chk(rv, 8'h00);
        chk(resetVector, vecExp(1'b1));
        cmd(8'h03, 3'h0);
        rd(CT);
        chk(rv, 8'h03);
        repeat (4) @(posedge core_clk);
        rd(CT);
        chk(rv, 8'h00);
        $display("test reset and window done");
        seed = xs(seed);
        ptr = {9'h1ff, seed[6:0]};
        setPtr(ptr);
        cmd(8'h83, 3'h4);
        repeat (7) @(posedge core_clk);
        #1 chk(cpuStall, 1'b1);
        chk(flashReq.erase, 1'b1);
        chk(flashReq.addr[15:7], ptr[15:7]);
        chk(concurrentBlocked, 1'b1);
        chk(irq, 1'b0);
        setPtr(16'h0000);
        cmd(8'h85, 3'h1);
        rd(CT);
        chk(rv, 8'hc3);
        chk(flashReq.addr[15:7], ptr[15:7]);
        waitIdle;
        chk(rv, 8'hc0);
        chk(irq, 1'b1);
        chk(concurrentBlocked, 1'b1);
        cmd(8'h91, 3'h0);
        rd(CT);
        chk(rv, 8'h80);
        chk(concurrentBlocked, 1'b0);
        $display("test halting erase done");
        seed = xs(seed);
        // stay below the halting section so no stall is expected
        setPtr({4'h0, seed[11:0]});
        cmd(8'h03, 3'h1);
        readAddr <= BOOT;
        repeat (4) @(posedge core_clk);
        #1 chk(cpuStall, 1'b0);
        chk(concurrentBlocked, 1'b0);
        readAddr <= 16'h0000;
        #1 chk(concurrentBlocked, 1'b1);
        waitIdle;
        cmd(8'h11, 3'h0);
        $display("test concurrent erase done");
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            load({9'h001, 3'h0, seed[2:0], seed[3]}, seed[31:16]);
        end
        setPtr(16'h0080);
        cmd(8'h05, 3'h3);
        repeat (7) @(posedge core_clk);
        #1 chk(flashReq.write, 1'b1);
        chk(flashReq.addr[15:7], 9'h001);
        waitIdle;
        cmd(8'h11, 3'h0);
        used = '0;
        load(16'h0080, seed[15:0]);
        $display("test load and write done");
        eepromBusy <= 1'b1;
        cmd(8'h03, 3'h0);
        rd(CT);
        chk(rv, 8'h00);
        eepromBusy <= 1'b0;
        used = '0;
        load(16'h0080, 16'h5a3c);
        $display("test eeprom interlock done");
        lockExp = fsp_pkg::LOCKS_RESET;
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            lockExp = lockNext(lockExp, seed[5:0]);
            wr(fsp_pkg::ADDR_DATA_LOW, {2'b11, seed[5:0]});
            setPtr(i == 0 ? 16'h0001 : seed[31:16]);
            cmd(8'h09, 3'h2);
            repeat (PROG - 4) @(posedge core_clk);
            #1 chk(cpuStall, 1'b0);
            chk(concurrentBlocked, 1'b0);
            rd(CT);
            chk(rv, 8'h09);
            waitIdle;
            rd(fsp_pkg::ADDR_LOCKS);
            chk(rv[5:0], lockExp);
        end
        $display("test lock setting done");
        final_report;
    end
endmodule // tb_flash_self_programming_ctrl
